// [hw/mrx_pkg.sv]
// Shared constants for the receive pin block and strap latch
package mrx_pkg;
  // System clock rate in hertz
  localparam int unsigned CLK_HZ = 125_000_000;
  // Receive clock rate at 100 Mb/s, in hertz
  localparam int unsigned RXC_FAST_HZ = 25_000_000;
  // Receive clock rate at 10 Mb/s, in hertz
  localparam int unsigned RXC_SLOW_HZ = 2_500_000;
  // Receive clock periods in system clock cycles
  localparam int unsigned RXC_FAST_CYC = CLK_HZ / RXC_FAST_HZ;
  localparam int unsigned RXC_SLOW_CYC = CLK_HZ / RXC_SLOW_HZ;
  // Width of the divider counter
  localparam int unsigned DIV_W = 6;
  // Last strap counter value; the strap pins stay inputs while it counts 0 to 7 after reset release
  localparam logic [3:0] STRAP_LAST = 4'h7;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] MGMT_OFS = 12'h008;
  localparam logic [11:0] MSHIFT_OFS = 12'h00c;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [31:0] MGMT_RST = 32'h0000_0000;
  // Control register fields
  localparam int unsigned CTRL_SPEED_BIT = 0;
  localparam int unsigned CTRL_RUN_BIT = 1;
  // Management drive register fields
  localparam int unsigned MGMT_VAL_BIT = 0;
  localparam int unsigned MGMT_DRV_BIT = 1;
  // Status register fields
  localparam int unsigned STAT_LOOP_BIT = 5;
  localparam int unsigned STAT_ISO_BIT = 6;
  localparam int unsigned STAT_DONE_BIT = 7;
  localparam int unsigned STAT_SPEED_BIT = 8;
  // Width of the management sample shifter
  localparam int unsigned MSHIFT_W = 16;
  // Width of the synchronised pin group
  localparam int unsigned SYNC_W = 9;
endpackage

// [hw/mrx_sync3.sv]
// Three-stage pin synchroniser with agreement filter
module mrx_sync3 import mrx_pkg::*; #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous pin levels
  input wire logic [W-1:0] pin_in,
  // Filtered levels
  output logic [W-1:0] lvl_out
);
  // Three stages; the first feeds only the second
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Shift chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit changes only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          lvl_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// [hw/mrx_rxc_div.sv]
// Receive clock divider with data launch pulse
module mrx_rxc_div import mrx_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Speed select, high for 100 Mb/s
  input wire logic speed100,
  // Divided clock level and launch pulse on its falling edge
  output logic rxc_out,
  output logic fall_pulse,
  // Speed in force for the current period
  output logic speed_act
);
  // Period counter
  logic [DIV_W-1:0] cnt_reg;
  // Period and high time for the active speed
  logic [DIV_W-1:0] per_last;
  logic [DIV_W-1:0] hi_cyc;

  // Period length follows the speed latched at the last wrap
  always_comb begin
    if (speed_act) begin
      per_last = DIV_W'(RXC_FAST_CYC - 1);
      hi_cyc = DIV_W'((RXC_FAST_CYC + 1) / 2);
    end else begin
      per_last = DIV_W'(RXC_SLOW_CYC - 1);
      hi_cyc = DIV_W'((RXC_SLOW_CYC + 1) / 2);
    end
  end

  // Count periods; speed changes only on a period boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      speed_act <= 1'b1;
    end else if (cnt_reg == per_last) begin
      cnt_reg <= '0;
      speed_act <= speed100;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Clock high in the first part, pulse marks the fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxc_out <= 1'b0;
      fall_pulse <= 1'b0;
    end else begin
      rxc_out <= (cnt_reg < hi_cyc);
      fall_pulse <= (cnt_reg == hi_cyc);
    end
  end

  // Fast period is exactly five cycles while the speed holds
  a_fast_period: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rxc_out) && speed_act ##1 speed_act[*4] |=> $rose(rxc_out))
    else $error("fast receive clock period wrong");

  // Slow clock stays high exactly twenty-five cycles
  a_slow_high: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rxc_out) && !speed_act |-> ##25 $fell(rxc_out))
    else $error("slow receive clock high time wrong");
endmodule

// [hw/mrx_top.sv]
// Receive pin driver, strap latch and APB register slave
//
// The address map and register access over APB were decided locally.
module mrx_top import mrx_pkg::*; (
  // System clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive stream from the coding logic
  input wire logic [3:0] core_nib,
  input wire logic core_dv,
  input wire logic core_er,
  output logic core_take,
  // Receive data pins
  input wire logic [3:0] rxd_in,
  output logic [3:0] rxd_out,
  output logic [3:0] rxd_oe_n,
  // Receive data valid pin
  input wire logic rx_dv_in,
  output logic rx_dv_out,
  output logic rx_dv_oe_n,
  // Receive error pin
  input wire logic rx_er_in,
  output logic rx_er_out,
  output logic rx_er_oe_n,
  // Receive clock pin
  output logic rxc_out,
  // Lowest address strap from outside
  input wire logic strap_addr_bit0_in,
  // Management clock and data pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  // Latched configuration
  output logic [4:0] management_bus_address,
  output logic pcs_loopback_en,
  output logic isolate_en
);
  // Filtered pin levels
  logic [SYNC_W-1:0] pin_lvl;
  logic [3:0] rxd_s;
  logic dv_s;
  logic er_s;
  logic addr0_s;
  logic mdc_s;
  logic mdio_s;
  // Divider outputs
  logic rxc_q;
  logic launch;
  logic speed_act;
  // Software registers
  logic [31:0] ctrl_reg;
  logic [31:0] mgmt_reg;
  logic [MSHIFT_W-1:0] mshift_reg;
  // Strap sequence state
  logic [3:0] strap_cnt_reg;
  logic strap_done_reg;
  logic strap_latch;
  // Management clock edge tracking
  logic mdc_d_reg;
  logic mdc_rise;
  logic mdc_fall;
  // Bus decode
  logic apb_setup;
  logic apb_write;
  logic [31:0] rd_next;
  logic rd_hit;
  // Pins driven once straps are taken and not isolated
  logic drive_ok;

  // Pin group synchroniser
  mrx_sync3 #(
    .W(SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({mdio_in, mdc_in, strap_addr_bit0_in, rx_er_in, rx_dv_in,
             rxd_in}),
    .lvl_out(pin_lvl)
  );

  // Split the filtered group
  assign rxd_s = pin_lvl[3:0];
  assign dv_s = pin_lvl[4];
  assign er_s = pin_lvl[5];
  assign addr0_s = pin_lvl[6];
  assign mdc_s = pin_lvl[7];
  assign mdio_s = pin_lvl[8];

  // Receive clock generator
  mrx_rxc_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .speed100(ctrl_reg[CTRL_SPEED_BIT]),
    .rxc_out(rxc_q),
    .fall_pulse(launch),
    .speed_act(speed_act)
  );

  // Clock pin copy keeps the output a plain flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxc_out <= 1'b0;
    end else begin
      rxc_out <= rxc_q;
    end
  end

  // Strap window: pins stay inputs while the count runs
  assign strap_latch = !strap_done_reg && (strap_cnt_reg == STRAP_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_reg <= '0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 1'b1;
      strap_done_reg <= strap_latch;
    end
  end

  // Capture the straps once, then hold until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      management_bus_address <= '0;
      pcs_loopback_en <= 1'b0;
      isolate_en <= 1'b0;
    end else if (strap_latch) begin
      management_bus_address[0] <= addr0_s;
      management_bus_address[1] <= rxd_s[3];
      management_bus_address[2] <= rxd_s[2];
      management_bus_address[3] <= rxd_s[1];
      management_bus_address[4] <= rxd_s[0];
      pcs_loopback_en <= dv_s;
      isolate_en <= er_s;
    end
  end

  // Isolation releases the data, valid and error pins; the receive clock pin stays driven
  assign drive_ok = strap_done_reg && !isolate_en;

  // Output enables, active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_oe_n <= 4'hf;
      rx_dv_oe_n <= 1'b1;
      rx_er_oe_n <= 1'b1;
    end else begin
      rxd_oe_n <= {4{!drive_ok}};
      rx_dv_oe_n <= !drive_ok;
      rx_er_oe_n <= !drive_ok;
    end
  end

  // Launch a nibble on each receive clock fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_out <= '0;
      rx_dv_out <= 1'b0;
      rx_er_out <= 1'b0;
      core_take <= 1'b0;
    end else begin
      core_take <= 1'b0;
      if (launch) begin
        if (drive_ok && ctrl_reg[CTRL_RUN_BIT]) begin
          // Invalid content is forced to zero
          rxd_out <= core_dv ? core_nib : 4'h0;
          rx_dv_out <= core_dv;
          rx_er_out <= core_er;
          core_take <= 1'b1;
        end else begin
          // Stopped: idle the stream
          rxd_out <= 4'h0;
          rx_dv_out <= 1'b0;
          rx_er_out <= 1'b0;
        end
      end
    end
  end

  // Management clock edges
  assign mdc_rise = mdc_s && !mdc_d_reg;
  assign mdc_fall = !mdc_s && mdc_d_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdc_d_reg <= 1'b0;
    end else begin
      mdc_d_reg <= mdc_s;
    end
  end

  // Sample management data on each rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mshift_reg <= '0;
    end else if (mdc_rise) begin
      mshift_reg <= {mshift_reg[MSHIFT_W-2:0], mdio_s};
    end
  end

  // Drive management data only after a falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdio_out <= 1'b0;
      mdio_oe_n <= 1'b1;
    end else if (mdc_fall) begin
      mdio_out <= mgmt_reg[MGMT_VAL_BIT];
      mdio_oe_n <= !mgmt_reg[MGMT_DRV_BIT];
    end
  end

  // Bus phases
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;

  // Read mux and address check
  always_comb begin
    rd_next = '0;
    rd_hit = 1'b1;
    unique case (paddr)
      CTRL_OFS: rd_next = ctrl_reg;
      STAT_OFS: begin
        rd_next[4:0] = management_bus_address;
        rd_next[STAT_LOOP_BIT] = pcs_loopback_en;
        rd_next[STAT_ISO_BIT] = isolate_en;
        rd_next[STAT_DONE_BIT] = strap_done_reg;
        rd_next[STAT_SPEED_BIT] = speed_act;
      end
      MGMT_OFS: rd_next = mgmt_reg;
      MSHIFT_OFS: rd_next[MSHIFT_W-1:0] = mshift_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // No wait state: answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !rd_hit;
      // Read data only for a mapped read
      prdata <= (apb_setup && !pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  // Writable registers; status and shifter ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      mgmt_reg <= MGMT_RST;
    end else if (apb_write) begin
      if (paddr == CTRL_OFS) begin
        ctrl_reg <= {30'h0000_0000, pwdata[1:0]};
      end
      if (paddr == MGMT_OFS) begin
        mgmt_reg <= {30'h0000_0000, pwdata[1:0]};
      end
    end
  end

  // Nibble moves only right after a receive clock fall
  a_rxd_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(rxd_out) |-> $past(launch))
    else $error("receive nibble changed off the clock fall");

  // Content is zero whenever data valid is low
  a_dv_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_dv_out |-> rxd_out == 4'h0)
    else $error("nibble not idle while data valid low");

  // Address bits take the data pin levels in reverse order
  a_addr_capture: assert property (@(posedge pclk) disable iff (!presetn)
    strap_latch |=> management_bus_address[4:1] ==
      {$past(rxd_s[0]), $past(rxd_s[1]), $past(rxd_s[2]),
       $past(rxd_s[3])})
    else $error("address strap captured wrong");

  // Loopback follows the data valid strap
  a_loop_capture: assert property (@(posedge pclk) disable iff (!presetn)
    strap_latch |=> pcs_loopback_en == $past(dv_s))
    else $error("loopback strap captured wrong");

  // Isolation follows the error strap and sets the error pin enable to match
  a_iso_capture: assert property (@(posedge pclk) disable iff (!presetn)
    strap_latch |=> isolate_en == $past(er_s) ##1
      (isolate_en == rx_er_oe_n))
    else $error("isolate strap not applied");

  // Pins stay inputs until the strap window ends
  a_pins_released: assert property (@(posedge pclk) disable iff (!presetn)
    !strap_done_reg |-> rxd_oe_n == 4'hf && rx_dv_oe_n && rx_er_oe_n)
    else $error("strap pin driven during strap window");

  // Straps never move after the window
  a_straps_hold: assert property (@(posedge pclk) disable iff (!presetn)
    strap_done_reg && $past(strap_done_reg) |->
      $stable(management_bus_address) && $stable(pcs_loopback_en) &&
      $stable(isolate_en))
    else $error("latched strap changed after reset");

  // Management data drive changes only after a clock fall
  a_mdio_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(mdio_out) || $changed(mdio_oe_n) |-> $past(mdc_fall))
    else $error("management data changed off the clock fall");

  // Setup is answered in the next cycle
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");
endmodule

// [dv/mrx_mac_model.sv]
// MAC-side partner: strap pulls on released pins and nibble sampler
module mrx_mac_model (
  // Pin drive from the block
  input wire logic rxc,
  input wire logic [3:0] rxd_out,
  input wire logic [3:0] rxd_oe_n,
  input wire logic rx_dv_out,
  input wire logic rx_dv_oe_n,
  input wire logic rx_er_out,
  input wire logic rx_er_oe_n,
  // Pull levels and sampling enable
  input wire logic [5:0] pull,
  input wire logic listen,
  // Resolved pin levels
  output logic [3:0] rxd_in,
  output logic rx_dv_in,
  output logic rx_er_in,
  // Last sampled error and nibble, toggle per sample
  output logic [4:0] got,
  output logic got_tgl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins settle to their pull resistor
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rxd_in[i] = rxd_oe_n[i] ? pull[i] : rxd_out[i];
    end
    rx_dv_in = rx_dv_oe_n ? pull[4] : rx_dv_out;
    rx_er_in = rx_er_oe_n ? pull[5] : rx_er_out;
  end
  // Nothing sampled yet
  initial begin
    got = 5'h0;
    got_tgl = 1'b0;
  end
  // Take a nibble on receive clock rise, only while valid is high
  always @(posedge rxc) begin
    if (listen && rx_dv_in === 1'b1) begin
      got <= {rx_er_in, rxd_in};
      got_tgl <= ~got_tgl;
    end
  end
endmodule

// [dv/test_mrx_top.sv]
// Bench for the receive pins, strap latch and register slave
module test_mrx_top import mrx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Design and model signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, r, rc, rd;
  logic [3:0] core_nib, rxd_in, rxd_out, rxd_oe_n, rxd_prv;
  logic core_dv, core_er, core_take, rx_dv_in, rx_dv_out, rx_dv_oe_n;
  logic rx_er_in, rx_er_out, rx_er_oe_n, rxc_out, strap_addr_bit0_in;
  logic mdc_in, mdio_in, mdio_out, mdio_oe_n, mgr_mdio, err;
  logic pcs_loopback_en, isolate_en, listen, stream_on;
  logic got_tgl, tgl_prv, rxc_prv;
  logic [4:0] management_bus_address, got, ea;
  logic [5:0] pull;
  logic [4:0] exp_q[$];
  int miscompares, n_checks, per;
  // Shared data line: manager released means pull-up high
  assign mdio_in = mdio_oe_n ? mgr_mdio : mdio_out;
  mrx_top uut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .core_nib, .core_dv, .core_er, .core_take,
    .rxd_in, .rxd_out, .rxd_oe_n, .rx_dv_in, .rx_dv_out, .rx_dv_oe_n,
    .rx_er_in, .rx_er_out, .rx_er_oe_n, .rxc_out, .strap_addr_bit0_in,
    .mdc_in, .mdio_in, .mdio_out, .mdio_oe_n, .management_bus_address,
    .pcs_loopback_en, .isolate_en
  );
  mrx_mac_model mac (
    .rxc(rxc_out), .rxd_out, .rxd_oe_n, .rx_dv_out, .rx_dv_oe_n,
    .rx_er_out, .rx_er_oe_n, .pull, .listen, .rxd_in, .rx_dv_in,
    .rx_er_in, .got, .got_tgl
  );
  // System clock, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Pseudo-random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Report and end the run
  task give_verdict();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One APB transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only pready seen high ends this wait; the hang guard bounds it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset with given strap pulls, check pins released meanwhile
  task do_reset(input logic [5:0] p, input logic b0);
    @(posedge pclk);
    presetn <= 1'b0;
    pull <= p;
    strap_addr_bit0_in <= b0;
    repeat (5) @(posedge pclk);
    chk({26'h0, rxd_oe_n, rx_dv_oe_n, rx_er_oe_n}, 32'h3f);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
  endtask
  // Latched straps in status, outputs and pin drive
  task strap_chk(input logic [5:0] p, input logic b0);
    ea = {p[0], p[1], p[2], p[3], b0};
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rd, {23'h0, 2'b11, p[5], p[4], ea});
    chk({25'h0, management_bus_address, pcs_loopback_en, isolate_en},
      {25'h0, ea, p[4], p[5]});
    chk({26'h0, rxd_oe_n, rx_dv_oe_n, rx_er_oe_n},
      p[5] ? 32'h3f : 32'h0);
  endtask
  // Period of the receive clock in system cycles, rise to rise
  // Third rise skips a period still running at the old speed
  task rxc_period();
    int n;
    logic cur, prv;
    n = 0;
    cur = rxc_out;
    repeat (3) begin
      per = 0;
      do begin
        prv = cur;
        @(posedge pclk);
        cur = rxc_out;
        per++;
        n++;
      end while (!(cur === 1'b1 && prv === 1'b0) && n < 300);
    end
  endtask
  // Management frame, 160 ns clock, data changed while clock low
  task mdio_frame(input logic [15:0] b);
    for (int i = 15; i >= 0; i--) begin
      mdc_in <= 1'b0;
      mgr_mdio <= b[i];
      repeat (10) @(posedge pclk);
      mdc_in <= 1'b1;
      repeat (10) @(posedge pclk);
    end
    mdc_in <= 1'b0;
    mgr_mdio <= 1'b1;
    repeat (10) @(posedge pclk);
  endtask
  // Coding-side source: note each valid nibble as it is taken
  always @(posedge pclk) begin
    if (core_take === 1'b1) begin
      if (core_dv) exp_q.push_back({core_er, core_nib});
      rc = xs();
      core_nib <= rc[3:0];
      core_dv <= rc[4] | rc[5];
      core_er <= rc[6] & rc[7];
    end
  end
  // Output watcher: sampled nibbles and data change timing
  always @(posedge pclk) begin
    tgl_prv <= got_tgl;
    rxd_prv <= rxd_out;
    rxc_prv <= rxc_out;
    if (got_tgl !== tgl_prv) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk({27'h0, got}, {27'h0, exp_q.pop_front()});
    end
    if (stream_on && rxd_out !== rxd_prv) begin
      chk({30'h0, rxc_prv, rxc_out}, 32'h2);
    end
  end
  // Hang guard
  initial begin
    #200us;
    miscompares++;
    give_verdict();
  end
  // Main sequence
  initial begin
    seed = 32'h6764;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {core_nib, core_dv, core_er, strap_addr_bit0_in, mdc_in} = '0;
    {pull, tgl_prv, rxd_prv, rxc_prv, stream_on} = '0;
    mgr_mdio = 1'b1;
    listen = 1'b1;
    miscompares = 0;
    n_checks = 0;
    r = xs();
    do_reset({2'b00, r[3:0]}, r[4]);
    strap_chk({2'b00, r[3:0]}, r[4]);
    stream_on <= 1'b1;
    // Reset values and unmapped access
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, CTRL_RST);
    apb(1'b0, MGMT_OFS, 32'h0);
    chk(rd, MGMT_RST);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Slow then fast receive clock, stream kept running
    apb(1'b1, CTRL_OFS, 32'hffff_fffe);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h2);
    rxc_period();
    chk(per, RXC_SLOW_CYC);
    apb(1'b1, CTRL_OFS, 32'h3);
    rxc_period();
    chk(per, RXC_FAST_CYC);
    // Straps hold though pins and bit 0 input change
    r = xs();
    pull <= {2'b00, r[3:0]};
    strap_addr_bit0_in <= ~ea[0];
    repeat (30) @(posedge pclk);
    chk({27'h0, management_bus_address}, {27'h0, ea});
    // Management sampling and drive
    r = xs();
    mdio_frame(r[15:0]);
    apb(1'b0, MSHIFT_OFS, 32'h0);
    chk(rd, {16'h0, r[15:0]});
    apb(1'b1, MGMT_OFS, 32'h3);
    mdio_frame(16'hffff);
    chk({30'h0, mdio_oe_n, mdio_out}, 32'h1);
    // Stop the stream, every noted nibble must have been seen
    stream_on <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h1);
    repeat (20) @(posedge pclk);
    chk(32'(exp_q.size()), 32'h0);
    // Second reset: loopback and isolate straps set
    listen <= 1'b0;
    r = xs();
    do_reset({2'b11, r[3:0]}, r[4]);
    strap_chk({2'b11, r[3:0]}, r[4]);
    rxc_period();
    chk(per, RXC_FAST_CYC);
    chk(32'(exp_q.size()), 32'h0);
    give_verdict();
  end
endmodule
